// File: bench/lpcs_supervisor_tb.sv
// self-checking bench for the power-mode clock supervisor
`timescale 1ns/100ps
`default_nettype none
`include "lpcs_map.svh"
module lpcs_supervisor_tb;
    logic clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, periph_hsi_req = 1'b0, wdg_running = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000, rdata, d;
    logic [3:0] gpio_evt;
    logic [4:0] periph_wake;
    logic [2:0] standby_wake_pin, ahb_div, apb1_div, apb2_div, mco_sel;
    logic [1:0] sysclk_src;
    logic svd_out, comp1_evt, comp2_evt, ext_reset_pin_n, wdg_reset, alarm_a, alarm_b, tamper_evt, tstamp_evt;
    logic periodic_wake, hse_fail, lse_fail, msi_en, hsi_en, hse_en, pll_en, lse_en, lsi_en, clk_run;
    logic reg_lowpower, core_power_off, core_rst_n, cpu_wake, lcd_run, irq;
    int fail_count = 0, check_count = 0, n;
    int ks[9] = '{0, 4, 5, 6, 7, 8, 9, 10, 11};
    lpcs_supervisor uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .gpio_evt(gpio_evt), .svd_out(svd_out), .comp1_evt(comp1_evt), .comp2_evt(comp2_evt),
        .periph_wake(periph_wake), .periph_hsi_req(periph_hsi_req), .ext_reset_pin_n(ext_reset_pin_n),
        .wdg_reset(wdg_reset), .wdg_running(wdg_running), .standby_wake_pin(standby_wake_pin), .alarm_a(alarm_a),
        .alarm_b(alarm_b), .tamper_evt(tamper_evt), .tstamp_evt(tstamp_evt), .periodic_wake(periodic_wake),
        .hse_fail(hse_fail), .lse_fail(lse_fail), .msi_en(msi_en), .hsi_en(hsi_en), .hse_en(hse_en),
        .pll_en(pll_en), .lse_en(lse_en), .lsi_en(lsi_en), .clk_run(clk_run), .reg_lowpower(reg_lowpower),
        .core_power_off(core_power_off), .core_rst_n(core_rst_n), .cpu_wake(cpu_wake), .lcd_run(lcd_run),
        .sysclk_src(sysclk_src), .ahb_div(ahb_div), .apb1_div(apb1_div), .apb2_div(apb2_div),
        .mco_sel(mco_sel), .irq(irq));
    lpcs_wake_model pm (.clk(clk), .gpio_evt(gpio_evt), .svd_out(svd_out), .comp1_evt(comp1_evt),
        .comp2_evt(comp2_evt), .periph_wake(periph_wake), .ext_reset_pin_n(ext_reset_pin_n),
        .wdg_reset(wdg_reset), .standby_wake_pin(standby_wake_pin), .alarm_a(alarm_a), .alarm_b(alarm_b),
        .tamper_evt(tamper_evt), .tstamp_evt(tstamp_evt), .periodic_wake(periodic_wake),
        .hse_fail(hse_fail), .lse_fail(lse_fail));
    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // register port: one-cycle strobes, read data taken in the cycle after the strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    function automatic logic hit(input int s);
        case (s)
            0: hit = cpu_wake;
            1: hit = !core_rst_n;
            2: hit = core_rst_n;
            default: hit = (sysclk_src == `LPCS_SRC_HSI);
        endcase
    endfunction
    // bounded wait; a miss ends the run since later steps depend on it
    task automatic wait_on(input int s, input int lim);
        for (n = 0; n <= lim && hit(s) !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n > lim) begin
            fail_count++;
            $display("ERROR t=%0t wait %0d timed out", $time, s);
            final_report();
        end
    endtask
    task automatic t_stop(input int k);
        wr(`LPCS_A_CTRL, 32'h00000091);
        repeat (2) @(posedge clk);
        #1;
        chk({clk_run, reg_lowpower, pll_en, hse_en, msi_en, lcd_run}, 6'h11);
        chk(hsi_en, periph_hsi_req);
        chk(lsi_en, wdg_running);
        pm.pulse(k);
        wait_on(0, 70);
        rd(`LPCS_A_STATUS);
        chk(d[1:0], (k > 6) ? 2'h2 : 2'h1);
    endtask
    // w low: the event must be ignored, then a wake pin ends the mode
    task automatic t_stby(input int k, input logic [31:0] c, input logic w);
        wr(`LPCS_A_CSR, 32'h00000000);
        wr(`LPCS_A_CTRL, c);
        repeat (2) @(posedge clk);
        #1;
        chk({core_power_off, pll_en, hse_en, hsi_en, msi_en}, 5'h10);
        chk(lse_en | lsi_en, c[`LPCS_C_CAL] | wdg_running);
        pm.pulse(k);
        if (!w) begin
            repeat (200) @(posedge clk);
            #1;
            chk(core_power_off, 1'b1);
            pm.pulse(14);
        end
        wait_on(1, 1200);
        wait_on(2, 100);
        chk(sysclk_src, `LPCS_SRC_MSI);
        rd(`LPCS_A_CSR);
        chk(d[2], 1'b1);
        rd(`LPCS_A_CTRL);
        chk(d[10:8], c[10:8]);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk({msi_en, sysclk_src}, 3'h4);
        rd(8'h1C);
        chk(d, 32'h00000000);
        wr(`LPCS_A_CLKCFG, 32'h00002A20);
        repeat (2) @(posedge clk);
        #1;
        chk({mco_sel, apb2_div, apb1_div, ahb_div, sysclk_src}, 14'h2A20);
        wr(`LPCS_A_EVSEL, 32'h000000E4);
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            periph_hsi_req <= i[0];
            wdg_running <= i[1];
            t_stop(ks[i]);
        end
        // clock failure: masked first, then unmasked, then cleared by a status read
        wr(`LPCS_A_CLKCFG, 32'h00000002);
        wr(`LPCS_A_CTRL, 32'h00000020);
        pm.drive(22, 1'b1);
        wait_on(3, 50);
        chk(irq, 1'b0);
        wr(`LPCS_A_MASK, 32'h00000004);
        repeat (2) @(posedge clk);
        #1;
        chk(irq, 1'b1);
        pm.drive(22, 1'b0);
        rd(`LPCS_A_STATUS);
        chk(d[2], 1'b1);
        @(posedge clk);
        #1;
        chk(irq, 1'b0);
        // slow crystal monitor: calendar on the crystal, monitor enabled
        wr(`LPCS_A_CTRL, 32'h0000004C);
        pm.drive(23, 1'b1);
        repeat (3) @(posedge clk);
        pm.drive(23, 1'b0);
        rd(`LPCS_A_STATUS);
        chk(d[3], 1'b1);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk(sysclk_src, `LPCS_SRC_MSI);
        for (int k = 12; k < 22; k++) begin
            t_stby(k, 32'h00000706, 1'b1);
        end
        t_stby(17, 32'h00000702, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire

// File: bench/lpcs_wake_model.sv
// wake source model: event pins, reset pin, watchdog, calendar events and oscillator monitors
`timescale 1ns/100ps
`default_nettype none
module lpcs_wake_model (
    input wire logic clk, // system clock
    output logic [3:0] gpio_evt, // event pins
    output logic svd_out, // voltage detector
    output logic comp1_evt, // comparator 1
    output logic comp2_evt, // comparator 2
    output logic [4:0] periph_wake, // peripheral wake levels
    output logic ext_reset_pin_n, // reset pin, low active
    output logic wdg_reset, // watchdog reset
    output logic [2:0] standby_wake_pin, // wake pins
    output logic alarm_a, // alarm a
    output logic alarm_b, // alarm b
    output logic tamper_evt, // tamper
    output logic tstamp_evt, // timestamp
    output logic periodic_wake, // periodic wake
    output logic hse_fail, // external osc failed
    output logic lse_fail // slow crystal failed
);
    // one bit per source, index used by the bench: all sources idle at time zero
    logic [23:0] v = 24'h000000;
    logic pin_low;
    // reset pin kept as an active bit so every source pulses the same way
    assign {lse_fail, hse_fail, periodic_wake, tstamp_evt, tamper_evt, alarm_b, alarm_a, standby_wake_pin,
        wdg_reset, pin_low, periph_wake, comp2_evt, comp1_evt, svd_out, gpio_evt} = v;
    assign ext_reset_pin_n = ~pin_low;
    // level change right after an edge, never on it
    task automatic drive(input int k, input logic b);
        @(posedge clk);
        v[k] <= b;
    endtask
    // two-cycle event, long enough for level and rising-edge detectors
    task automatic pulse(input int k);
        drive(k, 1'b1);
        repeat (2) @(posedge clk);
        v[k] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: hw/lpcs_supervisor.sv
// power-mode, wake and clock supervision logic with register port
`timescale 1ns/100ps
`default_nettype none
`include "lpcs_map.svh"
module lpcs_supervisor (
    input wire logic clk, // 20 MHz
    input wire logic resetn, // power-on reset
    input wire logic [7:0] addr, // register byte address
    input wire logic [31:0] wdata, // write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd_en
    input wire logic [3:0] gpio_evt, // event line pin inputs
    input wire logic svd_out, // supply voltage detector
    input wire logic comp1_evt, // comparator 1 event
    input wire logic comp2_evt, // comparator 2 event
    input wire logic [4:0] periph_wake, // usb, usart, i2c, serial, counter
    input wire logic periph_hsi_req, // peripheral asks fast osc in stop
    input wire logic ext_reset_pin_n, // external reset pin
    input wire logic wdg_reset, // watchdog reset request
    input wire logic wdg_running, // watchdog needs its slow clock
    input wire logic [2:0] standby_wake_pin, // wake pins
    input wire logic alarm_a, // calendar alarm a
    input wire logic alarm_b, // calendar alarm b
    input wire logic tamper_evt, // calendar tamper
    input wire logic tstamp_evt, // calendar timestamp
    input wire logic periodic_wake, // calendar periodic wake
    input wire logic hse_fail, // external osc failure detect
    input wire logic lse_fail, // slow crystal failure detect
    output logic msi_en, // multispeed osc enable
    output logic hsi_en, // fast internal osc enable
    output logic hse_en, // external osc enable
    output logic pll_en, // pll enable
    output logic lse_en, // slow crystal enable
    output logic lsi_en, // slow rc enable
    output logic clk_run, // core clocks running
    output logic reg_lowpower, // regulator low-power
    output logic core_power_off, // core regulator off
    output logic core_rst_n, // processor reset
    output logic cpu_wake, // stop exit pulse
    output logic lcd_run, // lcd driver clock on
    output logic [1:0] sysclk_src, // system clock source
    output logic [2:0] ahb_div, // ahb log2 divider
    output logic [2:0] apb1_div, // apb1 log2 divider
    output logic [2:0] apb2_div, // apb2 log2 divider
    output logic [2:0] mco_sel, // clock output pin select
    output logic irq // interrupt level
);
    import lpcs_pkg::*;

    localparam int C_STOP = `LPCS_STOP_WAKE_CYC;
    localparam int C_STBY = `LPCS_STBY_WAKE_CYC;
    // range capped for the checker; the real exit takes a few dozen cycles
    localparam int C_STBY_CHK = (C_STBY > 1000) ? 1000 : C_STBY;

    lpcs_state_t state_reg;
    logic [10:0] cnt_reg;
    logic from_stby_reg;
    logic [10:0] ctrl_reg;
    logic [7:0] evsel_reg;
    logic [3:0] status_reg;
    logic [3:0] status_next;
    logic [3:0] mask_reg;
    logic [3:0] csr_reg;
    logic [2:0] pin_prev_reg;
    logic [2:0] pin_rise;
    logic ev_hit, stop_wake, stby_wake, cal_evt, css_hit, lcss_hit;
    logic wr_ctrl, wr_clk, cmd_stop, cmd_stby, core_clr;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////
    // helpers

    // source frequency in khz, used by limit check and assertion
    function automatic logic [15:0] src_khz(input logic [1:0] s);
        case (s)
            `LPCS_SRC_MSI: src_khz = `LPCS_KHZ_MSI;
            `LPCS_SRC_HSI: src_khz = `LPCS_KHZ_HSI;
            `LPCS_SRC_HSE: src_khz = `LPCS_KHZ_HSE;
            default: src_khz = `LPCS_KHZ_PLL;
        endcase
    endfunction

    // one event line, source chosen by a two-bit select
    function automatic logic ev_line(input logic [1:0] sel, input logic pin);
        case (sel)
            2'h0: ev_line = pin;
            2'h1: ev_line = svd_out;
            2'h2: ev_line = comp1_evt;
            default: ev_line = comp2_evt & ctrl_reg[`LPCS_C_VREF];
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    // wake decode
    always_comb begin
        ev_hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            ev_hit = ev_hit | ev_line(evsel_reg[2*i +: 2], gpio_evt[i]);
        end
    end
    assign lcss_hit = ctrl_reg[`LPCS_C_LCSS] & lse_fail & lse_en;
    // any event line, peripheral wake or slow crystal failure ends stop
    assign stop_wake = ev_hit | (|periph_wake) | lcss_hit | ~ext_reset_pin_n;
    assign pin_rise = standby_wake_pin & ~pin_prev_reg & ctrl_reg[`LPCS_C_PIN];
    assign cal_evt = wdg_reset | alarm_a | alarm_b | tamper_evt | tstamp_evt | periodic_wake;
    // without calendar only the pin reset and wake pins count
    assign stby_wake = ~ext_reset_pin_n | (|pin_rise) | (ctrl_reg[`LPCS_C_CAL] & cal_evt);
    assign css_hit = ctrl_reg[`LPCS_C_CSS] & hse_fail & sysclk_src[1] & (state_reg == ST_RUN);

    assign wr_ctrl = wr_en & (addr == `LPCS_A_CTRL);
    assign wr_clk = wr_en & (addr == `LPCS_A_CLKCFG);
    assign cmd_stop = wr_ctrl & wdata[`LPCS_C_STOP];
    assign cmd_stby = wr_ctrl & wdata[`LPCS_C_STBY];
    assign core_clr = (state_reg == ST_CRST);

    // wake pins sampled for edges; ordinary synchronous inputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_prev_reg <= 3'h0;
        end else begin
            pin_prev_reg <= standby_wake_pin;
        end
    end

    ////////////////////////////////////////////////////////////////
    // mode sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_RUN;
            cnt_reg <= 11'h000;
            from_stby_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (!ext_reset_pin_n || wdg_reset) begin
                        state_reg <= ST_CRST;
                        cnt_reg <= `LPCS_CORE_RST;
                    end else if (cmd_stby) begin
                        state_reg <= ST_STBY;
                    end else if (cmd_stop) begin
                        state_reg <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (stop_wake) begin
                        state_reg <= ST_WAKE;
                        cnt_reg <= `LPCS_OSC_SETTLE;
                        from_stby_reg <= 1'b0;
                    end
                end
                ST_STBY: begin
                    if (stby_wake) begin
                        state_reg <= ST_WAKE;
                        cnt_reg <= `LPCS_OSC_SETTLE;
                        from_stby_reg <= 1'b1;
                    end
                end
                ST_WAKE: begin
                    if (cnt_reg != 11'h000) begin
                        cnt_reg <= cnt_reg - 11'h001;
                    end else if (from_stby_reg) begin
                        // core state is gone, so restart through reset
                        state_reg <= ST_CRST;
                        cnt_reg <= `LPCS_CORE_RST;
                    end else begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_CRST: begin
                    if (cnt_reg != 11'h000) begin
                        cnt_reg <= cnt_reg - 11'h001;
                    end else begin
                        state_reg <= ST_RUN;
                        from_stby_reg <= 1'b0;
                    end
                end
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // oscillator, regulator and core controls, lagging state by one cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            msi_en <= 1'b1;
            hsi_en <= 1'b0;
            hse_en <= 1'b0;
            pll_en <= 1'b0;
            lse_en <= 1'b0;
            lsi_en <= 1'b0;
            clk_run <= 1'b1;
            reg_lowpower <= 1'b0;
            core_power_off <= 1'b0;
            core_rst_n <= 1'b0;
            cpu_wake <= 1'b0;
            lcd_run <= 1'b0;
        end else begin
            // calendar and watchdog clocks follow their own users in all modes
            lse_en <= ctrl_reg[`LPCS_C_CAL] & ctrl_reg[`LPCS_C_CALLSE];
            lsi_en <= (ctrl_reg[`LPCS_C_CAL] & ~ctrl_reg[`LPCS_C_CALLSE]) | wdg_running;
            core_rst_n <= (state_reg != ST_CRST);
            cpu_wake <= (state_reg == ST_WAKE) && (cnt_reg == 11'h000) && !from_stby_reg;
            case (state_reg)
                ST_STOP: begin
                    msi_en <= 1'b0;
                    hsi_en <= periph_hsi_req;
                    hse_en <= 1'b0;
                    pll_en <= 1'b0;
                    clk_run <= 1'b0;
                    reg_lowpower <= 1'b1;
                    core_power_off <= 1'b0;
                    lcd_run <= ctrl_reg[`LPCS_C_LCD];
                end
                ST_STBY: begin
                    msi_en <= 1'b0;
                    hsi_en <= 1'b0;
                    hse_en <= 1'b0;
                    pll_en <= 1'b0;
                    clk_run <= 1'b0;
                    reg_lowpower <= 1'b0;
                    core_power_off <= 1'b1;
                    lcd_run <= 1'b0;
                end
                default: begin
                    msi_en <= (sysclk_src == `LPCS_SRC_MSI);
                    hsi_en <= (sysclk_src == `LPCS_SRC_HSI);
                    hse_en <= sysclk_src[1];
                    pll_en <= (sysclk_src == `LPCS_SRC_PLL);
                    clk_run <= 1'b1;
                    reg_lowpower <= 1'b0;
                    core_power_off <= 1'b0;
                    lcd_run <= ctrl_reg[`LPCS_C_LCD];
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // control register; calendar and wake pin bits live in the standby domain
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= 11'h000;
        end else if (wr_ctrl) begin
            ctrl_reg <= wdata[10:0] & 11'h7FC; // command bits are not stored
        end else if (core_clr) begin
            ctrl_reg <= ctrl_reg & 11'h70C;
        end
    end

    // clock configuration; a write that would overclock ahb is dropped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sysclk_src <= `LPCS_SRC_MSI;
            ahb_div <= 3'h0;
            apb1_div <= 3'h0;
            apb2_div <= 3'h0;
            mco_sel <= 3'h0;
        end else if (core_clr) begin
            sysclk_src <= `LPCS_SRC_MSI;
            ahb_div <= 3'h0;
            apb1_div <= 3'h0;
            apb2_div <= 3'h0;
            mco_sel <= 3'h0;
        end else if (css_hit) begin
            sysclk_src <= `LPCS_SRC_HSI;
        end else if (wr_clk && ((src_khz(wdata[`LPCS_K_SRC]) >> wdata[`LPCS_K_AHB]) <= `LPCS_KHZ_MAX)) begin
            sysclk_src <= wdata[`LPCS_K_SRC];
            ahb_div <= wdata[`LPCS_K_AHB];
            apb1_div <= wdata[`LPCS_K_APB1];
            apb2_div <= wdata[`LPCS_K_APB2];
            mco_sel <= wdata[`LPCS_K_MCO];
        end
    end

    // event line selects and interrupt mask
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evsel_reg <= 8'h00;
            mask_reg <= 4'h0;
        end else if (core_clr) begin
            evsel_reg <= 8'h00;
            mask_reg <= 4'h0;
        end else begin
            if (wr_en && addr == `LPCS_A_EVSEL) begin
                evsel_reg <= wdata[7:0];
            end
            if (wr_en && addr == `LPCS_A_MASK) begin
                mask_reg <= wdata[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // sticky status, cleared by its read; a new event wins over the clear
    always_comb begin
        status_next = status_reg;
        if (rd_en && addr == `LPCS_A_STATUS) begin
            status_next = 4'h0;
        end
        status_next[`LPCS_S_EV] = status_next[`LPCS_S_EV] | ((state_reg == ST_STOP) & ev_hit);
        status_next[`LPCS_S_PER] = status_next[`LPCS_S_PER] | ((state_reg == ST_STOP) & (|periph_wake));
        status_next[`LPCS_S_HSE] = status_next[`LPCS_S_HSE] | css_hit;
        status_next[`LPCS_S_LSE] = status_next[`LPCS_S_LSE] | lcss_hit;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= 4'h0;
            irq <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq <= |(status_reg & mask_reg);
        end
    end

    // reset cause flags, kept across standby; any write to this register clears them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            csr_reg <= 4'h0;
        end else begin
            // a cause arriving with the clearing write is kept
            csr_reg <= ((wr_en && addr == `LPCS_A_CSR) ? 4'h0 : csr_reg)
                       | {(state_reg == ST_STBY) & (|pin_rise), (state_reg == ST_STBY) & stby_wake,
                                  wdg_reset, ~ext_reset_pin_n};
        end
    end

    ////////////////////////////////////////////////////////////////
    // read port; unmapped addresses read zero
    always_comb begin
        case (addr)
            `LPCS_A_CTRL: rd_mux = {21'h0, ctrl_reg};
            `LPCS_A_CLKCFG: rd_mux = {18'h0, mco_sel, apb2_div, apb1_div, ahb_div, sysclk_src};
            `LPCS_A_EVSEL: rd_mux = {24'h0, evsel_reg};
            `LPCS_A_STATUS: rd_mux = {28'h0, status_reg};
            `LPCS_A_MASK: rd_mux = {28'h0, mask_reg};
            `LPCS_A_STATE: rd_mux = {23'h0, state_reg, msi_en, hsi_en, hse_en, pll_en, lse_en, lsi_en};
            `LPCS_A_CSR: rd_mux = {28'h0, csr_reg};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0;
        end else begin
            rdata <= rd_en ? rd_mux : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    sequence s_stop_exit;
        (state_reg == ST_STOP) && stop_wake;
    endsequence
    sequence s_stby_exit;
        (state_reg == ST_STBY) && stby_wake;
    endsequence

    a_stop_clocks_off: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == ST_STOP) |=> (!clk_run && !msi_en && !pll_en && !hse_en && reg_lowpower))
        else $error("stop left a clock running");
    a_stop_hsi_req: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == ST_STOP) |=> (hsi_en == $past(periph_hsi_req)))
        else $error("fast osc not following peripheral request");
    a_stop_wake_time: assert property (@(posedge clk) disable iff (!resetn)
        s_stop_exit |-> ##[1:C_STOP] cpu_wake)
        else $error("stop exit too slow");
    a_comp2_gated: assert property (@(posedge clk) disable iff (!resetn)
        ((state_reg == ST_STOP) && (evsel_reg == 8'hFF) && !ctrl_reg[`LPCS_C_VREF] && periph_wake == 5'h0
         && ext_reset_pin_n && !lcss_hit) |=> (state_reg == ST_STOP))
        else $error("comparator 2 woke without reference");
    a_periph_wake: assert property (@(posedge clk) disable iff (!resetn)
        ((state_reg == ST_STOP) && |periph_wake) |=> (state_reg == ST_WAKE))
        else $error("peripheral wake ignored");
    a_stby_cal_osc: assert property (@(posedge clk) disable iff (!resetn)
        ((state_reg == ST_STBY) && ctrl_reg[`LPCS_C_CAL]) |=> ((lse_en || lsi_en) && !msi_en && !hsi_en && core_power_off))
        else $error("standby oscillators wrong with calendar");
    a_stby_exit_time: assert property (@(posedge clk) disable iff (!resetn)
        s_stby_exit |-> ##[1:C_STBY_CHK] $rose(core_rst_n))
        else $error("standby exit too slow");
    a_stby_no_cal: assert property (@(posedge clk) disable iff (!resetn)
        ((state_reg == ST_STBY) && !ctrl_reg[`LPCS_C_CAL] && ext_reset_pin_n && pin_rise == 3'h0)
        |=> (state_reg == ST_STBY) ##0 (!lse_en && (lsi_en == $past(wdg_running))))
        else $error("standby without calendar misbehaved");
    a_reset_clk: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == ST_CRST) |=> (sysclk_src == `LPCS_SRC_MSI && ahb_div == 3'h0))
        else $error("reset clock not multispeed");
    a_css_switch: assert property (@(posedge clk) disable iff (!resetn)
        css_hit |=> (sysclk_src == `LPCS_SRC_HSI && status_reg[`LPCS_S_HSE]))
        else $error("clock failure not handled");
    a_ahb_limit: assert property (@(posedge clk) disable iff (!resetn)
        (src_khz(sysclk_src) >> ahb_div) <= `LPCS_KHZ_MAX)
        else $error("ahb above limit");
endmodule
`default_nettype wire

// File: pkg/lpcs_map.svh
// register map, field positions and timing counts of the power-mode clock supervisor
// Contract
// - Stop halts clocks, oscillators and PLL, keeps state, regulator in low power.
// - A wake-capable peripheral may enable the high-speed internal oscillator during Stop.
// - Any external event line wakes Stop; processor resumes within 3.5 us.
// - Event line source: pin, voltage detector, comparator 1, comparator 2 if reference on.
// - USB, USART, I2C, low-power serial or counter wake events also exit Stop.
// - Standby with calendar: core regulator, PLL, fast oscillators off; one slow oscillator on.
// - Standby loses core state; standby-domain registers and status register survive.
// - Standby with calendar exits within 60 us on pin, watchdog, wake pins, calendar events.
// - Standby without calendar: all oscillators off; exit only on reset pin or wake pin. The code keeps the slow rc on while wdg_running.
// - Stop or Standby never halts calendar or watchdog clocks; Stop never halts LCD.
// - After any reset the system clock is the 2.1 MHz multispeed oscillator.
// - Enabled monitor: external oscillator failure switches clock to internal, raises interrupt.
// - Enabled slow crystal monitor raises interrupt or wake event on its failure.
// - Clock output pin carries one software-selected internal clock.
// - Separate AHB and two APB prescalers; none of these clocks above 32 MHz.
`ifndef LPCS_MAP_SVH
`define LPCS_MAP_SVH
`define LPCS_CLK_NS 50
`define LPCS_STOP_WAKE_NS 3500
`define LPCS_STOP_WAKE_CYC (`LPCS_STOP_WAKE_NS / `LPCS_CLK_NS)
`define LPCS_STBY_WAKE_NS 60000
`define LPCS_STBY_WAKE_CYC (`LPCS_STBY_WAKE_NS / `LPCS_CLK_NS)
`define LPCS_OSC_SETTLE 11'h010
`define LPCS_CORE_RST 11'h020
`define LPCS_A_CTRL 8'h00
`define LPCS_A_CLKCFG 8'h04
`define LPCS_A_EVSEL 8'h08
`define LPCS_A_STATUS 8'h0C
`define LPCS_A_MASK 8'h10
`define LPCS_A_STATE 8'h14
`define LPCS_A_CSR 8'h18
`define LPCS_C_STOP 0
`define LPCS_C_STBY 1
`define LPCS_C_CAL 2
`define LPCS_C_CALLSE 3
`define LPCS_C_VREF 4
`define LPCS_C_CSS 5
`define LPCS_C_LCSS 6
`define LPCS_C_LCD 7
`define LPCS_C_PIN 10:8
`define LPCS_K_SRC 1:0
`define LPCS_K_AHB 4:2
`define LPCS_K_APB1 7:5
`define LPCS_K_APB2 10:8
`define LPCS_K_MCO 13:11
`define LPCS_S_EV 0
`define LPCS_S_PER 1
`define LPCS_S_HSE 2
`define LPCS_S_LSE 3
`define LPCS_SRC_MSI 2'h0
`define LPCS_SRC_HSI 2'h1
`define LPCS_SRC_HSE 2'h2
`define LPCS_SRC_PLL 2'h3
`define LPCS_KHZ_MSI 16'h0834
`define LPCS_KHZ_HSI 16'h3E80
`define LPCS_KHZ_HSE 16'h5DC0
`define LPCS_KHZ_PLL 16'h7D00
`define LPCS_KHZ_MAX 16'h7D00
`endif

// File: pkg/lpcs_pkg.sv
// types shared by the power-mode clock supervisor
`default_nettype none
package lpcs_pkg;
    typedef enum logic [2:0] {ST_RUN, ST_STOP, ST_STBY, ST_WAKE, ST_CRST} lpcs_state_t;
endpackage
`default_nettype wire
